// >>> rtl/imi_top.sv
// Multimaster I2C bus interface with an AXI4-Lite register port.
//
// How it works
// - Slave role after reset and when idle.
// - Generated start switches the block to master.
// - Arbitration loss or own stop returns slave.
// - Master drives the clock line for transfers.
// - Start and stop only on software request.
// - Slave matches own 7/10-bit or general call.
// - General call matching has a software enable.
// - Bytes shift eight bits, MSB first.
// - First byte(s) after start carry address.
// - Only the master ever sends the address.
// - Ninth clock carries receiver acknowledge.
// - Acknowledge generation has a software enable.
// - Own address and general call programmable.
// - Software picks standard or fast speed.
// - Hold clock low until transmit byte written.
// - Hold clock low until received byte read.
// - Clock comes from a programmable divider.
// - Disabled block releases both bus pins.
// - Handshake by flags or enabled event output.
// - Start taken only while bus is free.
// - Misplaced start/stop sets bus error flag.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "imi_defines.svh"
module imi_top (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        serialDataPin,
   output logic             serialDataOut,
   output logic             serialDataOe,
   input  wire logic        serialClockPin,
   output logic             serialClockOut,
   output logic             serialClockOe,
   output logic             evtIrq
);
   imi_pkg::imi_mst_t mst_q, mst_d;
   logic [1:0]  sdaSync_q, sclSync_q;
   logic        sda_q, scl_q, awready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [6:0]  ctrl_q, flag_q;
   logic [15:0] oadr_q, div_q;
   logic [7:0]  tmr_q, tmr_d, sh_q, dr_q;
   logic [3:0]  cnt_q;
   logic [1:0]  phase_q;
   logic        msl_q, tra_q, sel_q, ten_q, gc_q, busy_q, hold_q;
   logic        engLow_q, adrByte_q, sdaOe_q, sclOe_q, irq_q;

   wire sdaLine  = sdaSync_q[1];
   wire sclLine  = sclSync_q[1];
   wire sclRise  = sclLine & ~scl_q;
   wire sclFall  = ~sclLine & scl_q;
   wire startDet = sclLine & scl_q & sda_q & ~sdaLine;
   wire stopDet  = sclLine & scl_q & ~sda_q & sdaLine;
   wire ctrlPe   = ctrl_q[`IMI_C_PE];
   wire ctrlAck  = ctrl_q[`IMI_C_ACK];
   wire startReq = ctrl_q[`IMI_C_START];
   wire stopReq  = ctrl_q[`IMI_C_STOP];
   wire tenMode  = oadr_q[`IMI_OA_TEN];
   wire cntAck   = cnt_q == `IMI_CNT_ACK;
   wire cntEnd   = cnt_q == `IMI_CNT_END;
   wire cntData  = cnt_q < `IMI_CNT_ACK;
   wire fall8    = sclFall & cntAck;
   wire fall9    = sclFall & cntEnd;
   wire tmrDone  = tmr_q == 8'h00;

   // Register bus decode.
   wire wrFire  = awready_q & s_axi_awvalid & s_axi_wvalid;
   wire rdFire  = arready_q & s_axi_arvalid;
   wire wrGo    = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
   wire rdGo    = s_axi_arvalid & ~arready_q & ~rvalid_q;
   wire wCtrl   = s_axi_awaddr == `IMI_A_CTRL;
   wire wStat   = s_axi_awaddr == `IMI_A_STAT;
   wire wData   = s_axi_awaddr == `IMI_A_DATA;
   wire wOadr   = s_axi_awaddr == `IMI_A_OADR;
   wire wCdiv   = s_axi_awaddr == `IMI_A_CDIV;
   wire wMapped = wCtrl | wStat | wData | wOadr | wCdiv;
   wire rCtrl   = s_axi_araddr == `IMI_A_CTRL;
   wire rStat   = s_axi_araddr == `IMI_A_STAT;
   wire rData   = s_axi_araddr == `IMI_A_DATA;
   wire rOadr   = s_axi_araddr == `IMI_A_OADR;
   wire rCdiv   = s_axi_araddr == `IMI_A_CDIV;
   wire rMapped = rCtrl | rStat | rData | rOadr | rCdiv;
   wire lane0   = s_axi_wstrb[0];
   wire [15:0] wMask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   wire drWr    = wrFire & wData & lane0;
   wire drRd    = rdFire & rData;
   wire drAcc   = drWr | drRd;
   wire drLoad  = drWr & (hold_q | mst_q == imi_pkg::ST_WAIT);

   // Address matching.
   wire hdrHit  = tenMode & sh_q[7:3] == `IMI_HDR
                  & sh_q[2:1] == oadr_q[9:8];
   wire m7Hit   = ~tenMode & sh_q[7:1] == oadr_q[6:0];
   wire gcHit   = ctrl_q[`IMI_C_ENGC] & sh_q == `IMI_GC;
   wire ph1     = phase_q == 2'h1;
   wire ph2     = phase_q == 2'h2;
   wire hdrOnly = ph1 & hdrHit & ~sh_q[0];
   wire firstHit = ph1 & (m7Hit | gcHit | hdrOnly
                   | hdrHit & sh_q[0] & ten_q);
   wire secondHit = ph2 & sh_q == oadr_q[7:0];
   wire addrHit = ~msl_q & (firstHit | secondHit);
   wire selHit  = addrHit & ~hdrOnly;
   wire txAct   = tra_q & (msl_q | sel_q);
   wire ackOut  = ctrlAck & (~tra_q & (msl_q | sel_q) | addrHit);

   // Event sources.
   wire staTake = mst_q == imi_pkg::ST_IDLE & startReq
                  & ~busy_q & ctrlPe;
   wire rsTake  = mst_q == imi_pkg::ST_WAIT & ~stopReq & startReq;
   wire stopDone = mst_q == imi_pkg::ST_SP3 & tmrDone;
   wire sbSet   = mst_q == imi_pkg::ST_STA & tmrDone;
   wire adslSet = fall8 & selHit;
   wire btfSet  = fall9 & (msl_q | sel_q & ~adrByte_q);
   wire afSet   = sclRise & cntAck & txAct & sdaLine;
   wire arloSet = sclRise & cntData & msl_q & tra_q
                  & ~engLow_q & ~sdaLine;
   wire berrSet = (startDet | stopDet) & cnt_q != 4'h0;
   wire stopfSet = stopDet & sel_q;
   wire [6:0] flagSet = {arloSet, stopfSet, berrSet, afSet,
                         btfSet, adslSet, sbSet};
   wire [6:0] flagClr = ({7{wrFire & wStat & lane0}} & s_axi_wdata[6:0])
                        | ({7{drAcc}} & 7'h07);
   wire evf = |flag_q;
   wire [31:0] statWord = {20'h00000, gc_q, tra_q, msl_q, busy_q,
                           evf, flag_q};
   wire [31:0] rdMux = rCtrl ? {25'h0000000, ctrl_q} :
                       rStat ? statWord :
                       rData ? {24'h000000, dr_q} :
                       rOadr ? {16'h0000, oadr_q} :
                       rCdiv ? {16'h0000, div_q} : 32'h00000000;
   wire [7:0] halfCnt = ctrl_q[`IMI_C_FAST] ? div_q[15:8] : div_q[7:0];
   wire sdaLowM = mst_q == imi_pkg::ST_STA | mst_q == imi_pkg::ST_SP1
                  | mst_q == imi_pkg::ST_SP2;
   // Data stays low in the wait state so it never rises with clock high.
   wire keepLow = sdaOe_q & (mst_q == imi_pkg::ST_WAIT);
   wire sclLowM = mst_q == imi_pkg::ST_WAIT | mst_q == imi_pkg::ST_LOW
                  | mst_q == imi_pkg::ST_RS1 | mst_q == imi_pkg::ST_SP1;
   wire msl_d   = (staTake | msl_q) & ~arloSet & ~stopDone & ctrlPe;

   // Bus pins pass two flip-flops before use.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         sdaSync_q <= 2'h3;
         sclSync_q <= 2'h3;
         sda_q     <= 1'b1;
         scl_q     <= 1'b1;
      end
      else
      begin
         sdaSync_q <= {sdaSync_q[0], serialDataPin};
         sclSync_q <= {sclSync_q[0], serialClockPin};
         sda_q     <= sdaSync_q[1];
         scl_q     <= sclSync_q[1];
      end

   // AXI4-Lite handshakes.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         awready_q <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `IMI_RESP_OK;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rresp_q   <= `IMI_RESP_OK;
         rdata_q   <= 32'h00000000;
      end
      else
      begin
         awready_q <= wrGo;
         arready_q <= rdGo;
         if (wrFire)
         begin
            bvalid_q <= 1'b1;
            bresp_q  <= wMapped ? `IMI_RESP_OK : `IMI_RESP_ERR;
         end
         else if (s_axi_bready)
            bvalid_q <= 1'b0;
         if (rdFire)
         begin
            rvalid_q <= 1'b1;
            rresp_q  <= rMapped ? `IMI_RESP_OK : `IMI_RESP_ERR;
            rdata_q  <= rdMux;
         end
         else if (s_axi_rready)
            rvalid_q <= 1'b0;
      end

   // Software registers; start and stop bits clear when carried out.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         ctrl_q <= `IMI_CTRL_RST;
         oadr_q <= `IMI_OADR_RST;
         div_q  <= `IMI_CDIV_RST;
         flag_q <= 7'h00;
      end
      else
      begin
         if (wrFire & wCtrl & lane0)
            ctrl_q <= s_axi_wdata[6:0];
         else
         begin
            ctrl_q[`IMI_C_START] <= startReq & ~staTake & ~rsTake;
            ctrl_q[`IMI_C_STOP]  <= stopReq & ~stopDone;
         end
         if (wrFire & wOadr)
            oadr_q <= oadr_q & ~wMask | s_axi_wdata[15:0] & wMask;
         if (wrFire & wCdiv)
            div_q <= div_q & ~wMask | s_axi_wdata[15:0] & wMask;
         flag_q <= ctrlPe ? flag_q & ~flagClr | flagSet : 7'h00;
      end

   // Master sequencer: start, clock phases, repeated start and stop.
   always_comb
   begin
      mst_d = mst_q;
      tmr_d = tmrDone ? 8'h00 : tmr_q - 8'h01;
      case (mst_q)
         imi_pkg::ST_IDLE:
            if (staTake)
            begin
               mst_d = imi_pkg::ST_STA;
               tmr_d = halfCnt;
            end
         imi_pkg::ST_STA:
            if (tmrDone)
               mst_d = imi_pkg::ST_WAIT;
         imi_pkg::ST_WAIT:
            if (stopReq | startReq | drAcc)
            begin
               mst_d = stopReq ? imi_pkg::ST_SP1 :
                       startReq ? imi_pkg::ST_RS1 : imi_pkg::ST_LOW;
               tmr_d = halfCnt;
            end
         imi_pkg::ST_LOW, imi_pkg::ST_RS1, imi_pkg::ST_SP1:
            if (tmrDone)
            begin
               mst_d = mst_q == imi_pkg::ST_LOW ? imi_pkg::ST_HIGH :
                       mst_q == imi_pkg::ST_RS1 ? imi_pkg::ST_RS2 :
                       imi_pkg::ST_SP2;
               tmr_d = halfCnt;
            end
         imi_pkg::ST_HIGH, imi_pkg::ST_RS2, imi_pkg::ST_SP2:
            if (!sclLine)
               tmr_d = halfCnt;
            else if (tmrDone)
            begin
               mst_d = mst_q == imi_pkg::ST_RS2 ? imi_pkg::ST_STA :
                       mst_q == imi_pkg::ST_SP2 ? imi_pkg::ST_SP3 :
                       cntEnd ? imi_pkg::ST_WAIT : imi_pkg::ST_LOW;
               tmr_d = halfCnt;
            end
         imi_pkg::ST_SP3:
            if (tmrDone)
               mst_d = imi_pkg::ST_IDLE;
         default:
            mst_d = imi_pkg::ST_IDLE;
      endcase
      if (arloSet | ~ctrlPe)
         mst_d = imi_pkg::ST_IDLE;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         mst_q <= imi_pkg::ST_IDLE;
         tmr_q <= 8'h00;
         msl_q <= 1'b0;
      end
      else
      begin
         mst_q <= mst_d;
         tmr_q <= tmr_d;
         msl_q <= msl_d;
      end

   // Bit counter, address phase and bus busy tracking.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         cnt_q     <= 4'h0;
         phase_q   <= 2'h0;
         adrByte_q <= 1'b0;
         busy_q    <= 1'b0;
      end
      else if (!ctrlPe | startDet | stopDet)
      begin
         cnt_q   <= 4'h0;
         phase_q <= {1'b0, ctrlPe & startDet};
         busy_q  <= ctrlPe & startDet;
      end
      else
      begin
         if (sclRise & ~cntEnd)
            cnt_q <= cnt_q + 4'h1;
         else if (fall9)
            cnt_q <= 4'h0;
         if (fall8)
         begin
            adrByte_q <= phase_q != 2'h0;
            phase_q   <= {~msl_q & hdrOnly, 1'b0};
         end
      end

   // Shift register, MSB first, and received byte latch.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         sh_q <= 8'h00;
         dr_q <= 8'h00;
      end
      else
      begin
         if (drLoad)
            sh_q <= s_axi_wdata[7:0];
         else if (sclRise & cntData)
            sh_q <= {sh_q[6:0], sdaLine};
         if (fall9)
            dr_q <= sh_q;
      end

   // Data line drive: data bits while clock low, then acknowledge.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         engLow_q <= 1'b0;
      else if (!ctrlPe | stopDet | afSet | arloSet)
         engLow_q <= 1'b0;
      else if (drLoad)
         engLow_q <= txAct & ~s_axi_wdata[7];
      else if (sclFall)
         engLow_q <= cnt_q == 4'h0 ? 1'b0 :
                     cntData ? txAct & ~sh_q[7] :
                     cntAck & ackOut;

   // Slave selection and transfer direction.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         sel_q <= 1'b0;
         tra_q <= 1'b0;
         ten_q <= 1'b0;
         gc_q  <= 1'b0;
      end
      else if (!ctrlPe | stopDet)
      begin
         sel_q <= 1'b0;
         tra_q <= 1'b0;
         ten_q <= 1'b0;
         gc_q  <= 1'b0;
      end
      else if (staTake)
         tra_q <= 1'b1;
      else if (startDet | afSet & ~msl_q)
         sel_q <= 1'b0;
      else if (fall8 & selHit)
      begin
         sel_q <= 1'b1;
         tra_q <= ph1 & sh_q[0];
         ten_q <= ten_q | ph2;
         gc_q  <= ph1 & gcHit;
      end
      else if (fall9 & msl_q & adrByte_q)
         tra_q <= ~sh_q[0];

   // Slave clock stretch until software services the data register.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         hold_q <= 1'b0;
      else if (!ctrlPe | startDet | stopDet)
         hold_q <= 1'b0;
      else if (fall9 & sel_q & ~msl_q)
         hold_q <= 1'b1;
      else if (drAcc)
         hold_q <= 1'b0;

   // Registered pin drives and event output.
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         sdaOe_q <= 1'b0;
         sclOe_q <= 1'b0;
         irq_q   <= 1'b0;
      end
      else
      begin
         sdaOe_q <= ctrlPe & (sdaLowM | keepLow | engLow_q);
         sclOe_q <= ctrlPe & (sclLowM | hold_q);
         irq_q   <= ctrl_q[`IMI_C_ITE] & evf;
      end

   assign s_axi_awready  = awready_q;
   assign s_axi_wready   = awready_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_arready  = arready_q;
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign s_axi_rvalid   = rvalid_q;
   assign serialDataOut  = 1'b0;
   assign serialClockOut = 1'b0;
   assign serialDataOe   = sdaOe_q;
   assign serialClockOe  = sclOe_q;
   assign evtIrq         = irq_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_disabled_pins: assert property (!ctrlPe |=> ##1 !serialDataOe
      && !serialClockOe) else $error("Pins driven while disabled.");
   a_start_free: assert property (mst_q == imi_pkg::ST_IDLE
      ##1 mst_q == imi_pkg::ST_STA |-> !$past(busy_q) && msl_q)
      else $error("Start issued on a busy bus.");
   a_arlo_slave: assert property (arloSet && ctrlPe |=> !msl_q
      && mst_q == imi_pkg::ST_IDLE && flag_q[`IMI_F_ARLO])
      else $error("Arbitration loss kept master role.");
   a_stop_slave: assert property (stopDone |=> !msl_q
      && !stopReq) else $error("Stop did not return to slave.");
   a_hold_scl: assert property (hold_q && ctrlPe
      |=> serialClockOe) else $error("Clock not held for software.");
   a_wait_scl: assert property (mst_q == imi_pkg::ST_WAIT
      && ctrlPe ##1 ctrlPe |-> serialClockOe)
      else $error("Master released clock while waiting.");
   a_ack_off: assert property (fall8 && !ctrlAck |=> !engLow_q
      ##1 !serialDataOe || sdaLowM) else $error("Acknowledge driven.");
   a_berr_flag: assert property (berrSet && ctrlPe |=> evf
      && flag_q[`IMI_F_BERR]) else $error("Bus error not flagged.");
   a_irq_gate: assert property (evf && ctrl_q[`IMI_C_ITE]
      ##1 evf |-> evtIrq) else $error("Event output not raised.");
endmodule // imi_top

// >>> rtl/imi_defines.svh
// Register offsets, field positions, reset values and counts of the I2C block.
`ifndef IMI_DEFINES_SVH
`define IMI_DEFINES_SVH
`define IMI_A_CTRL   8'h00
`define IMI_A_STAT   8'h04
`define IMI_A_DATA   8'h08
`define IMI_A_OADR   8'h0C
`define IMI_A_CDIV   8'h10
`define IMI_C_PE     0
`define IMI_C_START  1
`define IMI_C_STOP   2
`define IMI_C_ACK    3
`define IMI_C_ITE    4
`define IMI_C_ENGC   5
`define IMI_C_FAST   6
`define IMI_F_SB     0
`define IMI_F_ADSL   1
`define IMI_F_BTF    2
`define IMI_F_AF     3
`define IMI_F_BERR   4
`define IMI_F_STOPF  5
`define IMI_F_ARLO   6
`define IMI_OA_TEN   15
`define IMI_CTRL_RST 7'h00
`define IMI_OADR_RST 16'h0000
`define IMI_CDIV_RST 16'h32C8
`define IMI_HDR      5'h1E
`define IMI_GC       8'h00
`define IMI_CNT_ACK  4'h8
`define IMI_CNT_END  4'h9
`define IMI_RESP_OK  2'h0
`define IMI_RESP_ERR 2'h2
`endif

// >>> rtl/imi_pkg.sv
// Types shared by the I2C block.
package imi_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_STA  = 4'h1,
      ST_WAIT = 4'h2,
      ST_LOW  = 4'h3,
      ST_HIGH = 4'h4,
      ST_RS1  = 4'h5,
      ST_RS2  = 4'h6,
      ST_SP1  = 4'h7,
      ST_SP2  = 4'h8,
      ST_SP3  = 4'h9
   } imi_mst_t;
endpackage

// >>> verification/imi_bus_partner.sv
// Behavioural bus slave that answers one 7-bit address and can stretch.
`timescale 1ns/1ps
module imi_bus_partner #(
   parameter logic [6:0] OWN_ADDR = 7'h3A
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       slow,
   output logic            sdaOe,
   output logic            sclOe,
   output logic [7:0]      lastByte
);
   logic [7:0] shiftReg;
   int         bitCnt;
   logic       firstByte;
   logic       selected;
   initial
   begin
      sdaOe = 1'b0;
      sclOe = 1'b0;
      lastByte = 8'h00;
      bitCnt = 10;
      firstByte = 1'b0;
      selected = 1'b0;
   end
   always @(negedge sda)
      if (scl === 1'b1)
      begin
         bitCnt = 0;
         firstByte = 1'b1;
         selected = 1'b0;
      end
   always @(posedge sda)
      if (scl === 1'b1)
      begin
         bitCnt = 10;
         selected = 1'b0;
      end
   always @(posedge scl)
      if (bitCnt < 8)
      begin
         shiftReg = {shiftReg[6:0], sda};
         bitCnt++;
      end
   always @(negedge scl)
      if (bitCnt == 8)
      begin
         if (firstByte)
            selected = (shiftReg[7:1] == OWN_ADDR);
         if (selected && !firstByte)
            lastByte = shiftReg;
         sdaOe = selected;
         bitCnt = 9;
      end
      else if (bitCnt == 9)
      begin
         sdaOe = 1'b0;
         firstByte = 1'b0;
         bitCnt = selected ? 0 : 10;
         if (selected && slow)
         begin
            sclOe = 1'b1;
            #800;
            sclOe = 1'b0;
         end
      end
endmodule // imi_bus_partner

// >>> verification/imi_top_tb.sv
// Self-checking bench: register bus master, monitor and bus partner.
`timescale 1ns/1ps
`include "imi_defines.svh"
module imi_top_tb;
   typedef struct {
      logic [31:0] exp;
      logic [31:0] msk;
      logic [1:0]  rsp;
      logic        on;
   } imi_exp_t;
   logic        sys_clk, rst_n, slow;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, lastByte;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdLast, rnd, ctl;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        serialDataOe, serialClockOe, evtIrq, pSdaOe, pSclOe;
   logic        sdaLine, sclLine, sdaOut, sclOut;
   logic [3:0]  hs;
   imi_exp_t    expR[$];
   logic [1:0]  expB[$];
   imi_exp_t    eMon;
   int          errCount, checksDone, cyc, hiCnt, hiLast, half;
   assign sdaLine = ~serialDataOe & ~pSdaOe;
   assign sclLine = ~serialClockOe & ~pSclOe;
   assign hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid,
                s_axi_awready & s_axi_wready};
   imi_top u_imi_top (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .serialDataPin(sdaLine),
      .serialDataOut(sdaOut), .serialDataOe(serialDataOe),
      .serialClockPin(sclLine), .serialClockOut(sclOut),
      .serialClockOe(serialClockOe), .evtIrq(evtIrq));
   imi_bus_partner u_imi_bus_partner (
      .scl(sclLine), .sda(sdaLine), .slow(slow), .sdaOe(pSdaOe),
      .sclOe(pSclOe), .lastByte(lastByte));
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic reportAndStop();
      $display("checks %0d errors %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         errCount++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic waitHi(input int k);
      int n;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (hs[k] !== 1'b1 && n < 100);
      chk("handshake", {31'h0, hs[k]}, 32'h1);
   endtask
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
      @(posedge sys_clk);
      expB.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      waitHi(0);
      @(posedge sys_clk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      waitHi(1);
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axiRd(input logic [7:0] a, input imi_exp_t e);
      @(posedge sys_clk);
      expR.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      waitHi(2);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      waitHi(3);
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic readChk(input logic [7:0] a, input logic [31:0] x,
                          input logic [31:0] m, input logic [1:0] r);
      axiRd(a, '{x, m, r, 1'b1});
   endtask
   task automatic pollStat(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         axiRd(`IMI_A_STAT, '{32'h0, 32'h0, 2'h0, 1'b0});
         n++;
      end
      while (rdLast[b] !== v && n < 400);
      chk("poll", {31'h0, rdLast[b]}, {31'h0, v});
   endtask
   always @(negedge sys_clk)
   begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      begin
         eMon = expR.pop_front();
         rdLast = s_axi_rdata;
         if (eMon.on)
         begin
            chk("rdata", s_axi_rdata & eMon.msk, eMon.exp);
            chk("rresp", {30'h0, s_axi_rresp}, {30'h0, eMon.rsp});
         end
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         chk("bresp", {30'h0, s_axi_bresp}, {30'h0, expB.pop_front()});
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (sclLine === 1'b1)
         hiCnt <= hiCnt + 1;
      else
      begin
         if (hiCnt != 0)
            hiLast <= hiCnt;
         hiCnt <= 0;
      end
      if (cyc == 40000)
      begin
         errCount++;
         reportAndStop();
      end
   end
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, slow} = 3'h0;
      s_axi_wstrb = 4'hF;
      {errCount, checksDone, cyc, hiCnt, hiLast} = 160'h0;
      rnd = 32'h30;
      rst_n = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      readChk(`IMI_A_CTRL, 32'h0, 32'hFFFFFFFF, `IMI_RESP_OK);
      readChk(`IMI_A_STAT, 32'h0, 32'hFFFFFFFF, `IMI_RESP_OK);
      readChk(`IMI_A_OADR, 32'h0, 32'hFFFFFFFF, `IMI_RESP_OK);
      readChk(`IMI_A_CDIV, 32'h32C8, 32'hFFFFFFFF, `IMI_RESP_OK);
      axiWr(8'h14, 32'hFFFF, `IMI_RESP_ERR);
      readChk(8'h14, 32'h0, 32'hFFFFFFFF, `IMI_RESP_ERR);
      axiWr(`IMI_A_OADR, 32'h8155, `IMI_RESP_OK);
      readChk(`IMI_A_OADR, 32'h8155, 32'hFFFFFFFF, `IMI_RESP_OK);
      axiWr(`IMI_A_CTRL, 32'h28, `IMI_RESP_OK);
      readChk(`IMI_A_CTRL, 32'h28, 32'hFFFFFFFF, `IMI_RESP_OK);
      axiWr(`IMI_A_CDIV, 32'h0810, `IMI_RESP_OK);
      readChk(`IMI_A_CDIV, 32'h0810, 32'hFFFF, `IMI_RESP_OK);
      for (int m = 0; m < 3; m++)
      begin
         half = (m == 1) ? 8 : 16;
         slow = (m == 1);
         rnd = xs(rnd);
         ctl = (m == 0) ? 32'h19 : ((m == 1) ? 32'h49 : 32'h01);
         axiWr(`IMI_A_CTRL, ctl | 32'h2, `IMI_RESP_OK);
         pollStat(`IMI_F_SB, 1'b1);
         readChk(`IMI_A_STAT, 32'h201, 32'h201, `IMI_RESP_OK);
         repeat (40) @(negedge sys_clk);
         chk("clock hold", {31'h0, serialClockOe}, 32'h1);
         chk("event out", {31'h0, evtIrq}, {31'h0, m == 0});
         axiWr(`IMI_A_DATA, {24'h0, ((m == 2) ? 7'h55 : 7'h3A), 1'b0},
               `IMI_RESP_OK);
         pollStat((m == 2) ? `IMI_F_AF : `IMI_F_BTF, 1'b1);
         readChk(`IMI_A_STAT, (m == 2) ? 32'h8 : 32'h0, 32'h8,
                 `IMI_RESP_OK);
         if (m < 2)
         begin
            axiWr(`IMI_A_DATA, {24'h0, rnd[7:0]}, `IMI_RESP_OK);
            pollStat(`IMI_F_BTF, 1'b1);
         end
         else
         begin
            axiWr(`IMI_A_STAT, 32'h8, `IMI_RESP_OK);
            readChk(`IMI_A_STAT, 32'h0, 32'h8, `IMI_RESP_OK);
         end
         axiWr(`IMI_A_CTRL, ctl | 32'h4, `IMI_RESP_OK);
         pollStat(9, 1'b0);
         readChk(`IMI_A_STAT, 32'h0, 32'h200, `IMI_RESP_OK);
         if (m < 2)
         begin
            chk("byte", {24'h0, lastByte}, {24'h0, rnd[7:0]});
            chk("high", {31'h0, (hiLast >= half - 3 && hiLast <= half + 4)},
                32'h1);
         end
      end
      axiWr(`IMI_A_CTRL, 32'h0, `IMI_RESP_OK);
      repeat (4) @(negedge sys_clk);
      chk("data drive", {31'h0, serialDataOe}, 32'h0);
      chk("clock drive", {31'h0, serialClockOe}, 32'h0);
      chk("pin out", {30'h0, sdaOut, sclOut}, 32'h0);
      reportAndStop();
   end
endmodule // imi_top_tb
